// File: rtl/phy_mode_pkg.sv
package phy_mode_pkg;

    // ------------------------------------------------------------
    // Register indices (MII management register numbers)
    // ------------------------------------------------------------
    localparam logic [4:0] REG_MODE_CTRL_STAT = 5'h11;
    localparam logic [4:0] REG_SPECIAL_MODES = 5'h12;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int EDPD_EN_BIT = 13;
    localparam int ENERGY_BIT = 1;
    localparam int MODE_LSB = 5;
    localparam int ADDR_LSB = 0;

    // ------------------------------------------------------------
    // Operating mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_10_HD = 3'h0;
    localparam logic [2:0] MODE_10_FD = 3'h1;
    localparam logic [2:0] MODE_100_HD = 3'h2;
    localparam logic [2:0] MODE_100_FD = 3'h3;
    localparam logic [2:0] MODE_PWR_DOWN = 3'h6;
    localparam logic [2:0] MODE_ALL_CAP = 3'h7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_EDPD_EN = 1'b0;
    localparam logic RST_ENERGY = 1'b1;
    localparam logic [15:0] RST_ZERO = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int ENERGY_TIMEOUT_MS = 256;
    localparam int ENERGY_TIMEOUT_CYC = CLK_HZ / 1000 * ENERGY_TIMEOUT_MS;

    // Management access request
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] phy_addr;
        logic [4:0] reg_addr;
        logic [15:0] wdata;
    } mgmt_req_s;

    // Strap set for one PHY
    typedef struct packed {
        logic autoneg;
        logic speed;
        logic duplex;
        logic [4:0] addr;
    } straps_s;

    // Decoded operating mode
    typedef struct packed {
        logic power_down;
        logic autoneg_en;
        logic speed_100;
        logic full_duplex;
        logic crs_on_tx;
    } mode_dec_s;

endpackage

// File: rtl/phy_mode_config_regs.sv
// What this block does
// - Bit 13 enables energy-detect power-down, resets zero
// - Energy flag clears after 256ms without energy
// - Energy flag kept by soft reset, hardware sets
// - Bits 7:5 hold reset-selected operating mode
// - Port 1 external mode defaults to power-down
// - Autoneg strap one defaults mode to 111
// - Else mode is zero, speed, duplex straps
// - Straps captured at chip reset release
// - Bits 4:0 address; answer only that address
// - Address also seeds transmit scrambler key
// - Written address accepted without duplicate check
// - Address default comes from address strap
// - Sticky fields reset only by port PHY reset or chip reset
// - Loader rewrites special modes after reset/reload
// - Codes 000/001 select 10BASE-T half/full
// - Codes 010/011 select 100BASE-TX, CRS differs
// - 110 power-down, 111 all-capable, 100/101 reserved
`timescale 1ns/1ns

module phy_mode_config_regs #(
    parameter int TIMEOUT_CYC = phy_mode_pkg::ENERGY_TIMEOUT_CYC,
    parameter bit IS_PORT1 = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic port_phy_reset,
    input wire logic ext_mode_port1,
    input wire phy_mode_pkg::straps_s straps_raw,
    input wire logic energy_raw,
    input wire phy_mode_pkg::mgmt_req_s mgmt_req,
    input wire logic loader_write,
    input wire logic [15:0] loader_data,
    output logic mgmt_ack,
    output logic [15:0] mgmt_rdata,
    output logic low_power,
    output logic [4:0] scrambler_key,
    output phy_mode_pkg::mode_dec_s mode_dec
);

    if (TIMEOUT_CYC < 2) begin : g_bad_timeout
        $error("TIMEOUT_CYC too small");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // First stages are read only by second stages
    logic energy_s1_r;
    logic energy_s2_r;
    phy_mode_pkg::straps_s straps_s1_r;
    phy_mode_pkg::straps_s straps_s2_r;
    logic ext_s1_r;
    logic ext_s2_r;

    always_ff @(posedge clock) begin
        energy_s1_r <= energy_raw;
        energy_s2_r <= energy_s1_r;
        straps_s1_r <= straps_raw;
        straps_s2_r <= straps_s1_r;
        ext_s1_r <= ext_mode_port1;
        ext_s2_r <= ext_s1_r;
    end

    // ------------------------------------------------------------
    // Strap capture at reset release
    // ------------------------------------------------------------
    logic in_reset_r;
    phy_mode_pkg::straps_s straps_lat_r;
    logic ext_lat_r;

    // Captured on first edge after release; reset itself loads nothing
    wire capture = in_reset_r && rst_n;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            in_reset_r <= 1'b1;
        end else begin
            in_reset_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (capture) begin
            straps_lat_r <= straps_s2_r;
            ext_lat_r <= ext_s2_r;
        end
    end

    // ------------------------------------------------------------
    // Default mode and address
    // ------------------------------------------------------------
    wire phy_mode_pkg::straps_s st = capture ? straps_s2_r : straps_lat_r;
    wire ext_now = capture ? ext_s2_r : ext_lat_r;
    wire [2:0] man_mode = {1'b0, st.speed, st.duplex};
    wire [2:0] strap_mode = st.autoneg ? phy_mode_pkg::MODE_ALL_CAP
                                       : man_mode;
    wire [2:0] dflt_mode = (IS_PORT1 && ext_now)
                           ? phy_mode_pkg::MODE_PWR_DOWN
                           : strap_mode;
    wire [4:0] dflt_addr = st.addr;

    // ------------------------------------------------------------
    // Management decode
    // ------------------------------------------------------------
    logic edpd_en_r;
    logic energy_r;
    logic [2:0] mode_r;
    logic [4:0] addr_r;
    logic [$clog2(TIMEOUT_CYC)-1:0] quiet_cnt_r;

    wire addr_hit = mgmt_req.valid && (mgmt_req.phy_addr == addr_r);
    wire sel_mcs = mgmt_req.reg_addr == phy_mode_pkg::REG_MODE_CTRL_STAT;
    wire sel_spm = mgmt_req.reg_addr == phy_mode_pkg::REG_SPECIAL_MODES;
    wire wr_mcs = addr_hit && mgmt_req.write && sel_mcs;
    wire wr_spm = addr_hit && mgmt_req.write && sel_spm;
    wire sticky_rst = port_phy_reset || capture;

    wire [15:0] mcs_val = (16'h0001 << phy_mode_pkg::EDPD_EN_BIT)
                          & {16{edpd_en_r}}
                        | (16'h0001 << phy_mode_pkg::ENERGY_BIT)
                          & {16{energy_r}};
    wire [15:0] spm_val = {8'h00, mode_r, addr_r};
    wire [15:0] rd_val = sel_mcs ? mcs_val
                       : sel_spm ? spm_val
                       : phy_mode_pkg::RST_ZERO;

    // Handshake output may be combinational
    assign mgmt_ack = addr_hit;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mgmt_rdata <= phy_mode_pkg::RST_ZERO;
        end else if (addr_hit && !mgmt_req.write) begin
            mgmt_rdata <= rd_val;
        end
    end

    // ------------------------------------------------------------
    // Mode control/status register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n || soft_reset) begin
            edpd_en_r <= phy_mode_pkg::RST_EDPD_EN;
        end else if (wr_mcs) begin
            edpd_en_r <= mgmt_req.wdata[phy_mode_pkg::EDPD_EN_BIT];
        end
    end

    wire quiet_done = quiet_cnt_r ==
                      ($clog2(TIMEOUT_CYC))'(TIMEOUT_CYC - 1);

    // Soft reset is not a term here: flag survives it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            energy_r <= phy_mode_pkg::RST_ENERGY;
            quiet_cnt_r <= '0;
        end else if (energy_s2_r) begin
            energy_r <= 1'b1;
            quiet_cnt_r <= '0;
        end else if (quiet_done) begin
            energy_r <= 1'b0;
        end else begin
            quiet_cnt_r <= quiet_cnt_r + 1'b1;
        end
    end

    // Leaves low power as soon as the flag rises
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            low_power <= 1'b0;
        end else begin
            low_power <= edpd_en_r && !energy_r
                         && !energy_s2_r;
        end
    end

    // ------------------------------------------------------------
    // Special modes register
    // ------------------------------------------------------------
    // No uniqueness check against other PHY addresses
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_r <= phy_mode_pkg::MODE_PWR_DOWN;
            addr_r <= 5'h00;
        end else if (sticky_rst) begin
            mode_r <= dflt_mode;
            addr_r <= dflt_addr;
        end else if (loader_write) begin
            mode_r <= loader_data[phy_mode_pkg::MODE_LSB +: 3];
            addr_r <= loader_data[phy_mode_pkg::ADDR_LSB +: 5];
        end else if (wr_spm) begin
            mode_r <= mgmt_req.wdata[phy_mode_pkg::MODE_LSB +: 3];
            addr_r <= mgmt_req.wdata[phy_mode_pkg::ADDR_LSB +: 5];
        end
    end

    assign scrambler_key = addr_r;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_comb begin
        mode_dec = '0;
        case (mode_r)
            phy_mode_pkg::MODE_10_HD: mode_dec.crs_on_tx = 1'b1;
            phy_mode_pkg::MODE_10_FD: mode_dec.full_duplex = 1'b1;
            phy_mode_pkg::MODE_100_HD: begin
                mode_dec.speed_100 = 1'b1;
                mode_dec.crs_on_tx = 1'b1;
            end
            phy_mode_pkg::MODE_100_FD: begin
                mode_dec.speed_100 = 1'b1;
                mode_dec.full_duplex = 1'b1;
            end
            phy_mode_pkg::MODE_PWR_DOWN: mode_dec.power_down = 1'b1;
            phy_mode_pkg::MODE_ALL_CAP: mode_dec.autoneg_en = 1'b1;
            default: mode_dec = '0; // Reserved codes act as nothing
        endcase
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_quiet_run;
        !energy_s2_r [*8];
    endsequence
    sequence s_read_hit;
        addr_hit && !mgmt_req.write;
    endsequence
    sequence s_host_spm_write;
        wr_spm && !sticky_rst && !loader_write;
    endsequence
    a_edpd_write: assert property (
        @(posedge clock) disable iff (!rst_n)
        wr_mcs && !soft_reset |=> edpd_en_r ==
            $past(mgmt_req.wdata[phy_mode_pkg::EDPD_EN_BIT]))
        else $error("edpd enable not written");
    a_edpd_soft: assert property (
        @(posedge clock) disable iff (!rst_n)
        soft_reset |=> !edpd_en_r)
        else $error("edpd enable survived soft reset");
    a_energy_set: assert property (
        @(posedge clock) disable iff (!rst_n)
        energy_s2_r |=> energy_r)
        else $error("energy flag not set");
    a_energy_clear: assert property (
        @(posedge clock) disable iff (!rst_n)
        quiet_done && !energy_s2_r |=> !energy_r)
        else $error("energy flag not cleared at timeout");
    a_energy_soft: assert property (
        @(posedge clock) disable iff (!rst_n)
        soft_reset && !energy_s2_r && !quiet_done
            |=> energy_r == $past(energy_r))
        else $error("soft reset changed energy flag");
    a_energy_hw: assert property (
        @(posedge clock)
        !rst_n |=> energy_r)
        else $error("hardware reset did not set flag");
    a_energy_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        energy_r && !quiet_done |=> energy_r)
        else $error("energy flag cleared early");
    a_low_power: assert property (
        @(posedge clock) disable iff (!rst_n)
        s_quiet_run ##0 (edpd_en_r && !energy_r) |=> low_power)
        else $error("low power not entered");
    a_low_power_exit: assert property (
        @(posedge clock) disable iff (!rst_n)
        energy_s2_r || !edpd_en_r |=> !low_power)
        else $error("low power kept with energy present");
    a_default_mode: assert property (
        @(posedge clock) disable iff (!rst_n)
        sticky_rst |=> mode_r == $past(dflt_mode)
            && addr_r == $past(dflt_addr))
        else $error("defaults not loaded");
    a_ext_pd: assert property (
        @(posedge clock) disable iff (!rst_n)
        sticky_rst && IS_PORT1 && ext_now
            |=> mode_r == phy_mode_pkg::MODE_PWR_DOWN)
        else $error("external mode not power down");
    a_strap_auto: assert property (
        @(posedge clock) disable iff (!rst_n)
        capture && !(IS_PORT1 && ext_s2_r) && straps_s2_r.autoneg
            |=> mode_r == phy_mode_pkg::MODE_ALL_CAP)
        else $error("autoneg strap default wrong");
    a_strap_manual: assert property (
        @(posedge clock) disable iff (!rst_n)
        capture && !(IS_PORT1 && ext_s2_r) && !straps_s2_r.autoneg
            |=> mode_r == {1'b0, $past(straps_s2_r.speed),
                           $past(straps_s2_r.duplex)})
        else $error("manual strap default wrong");
    a_strap_capture: assert property (
        @(posedge clock) disable iff (!rst_n)
        !capture |=> $stable(straps_lat_r) && $stable(ext_lat_r))
        else $error("straps latched outside reset release");
    a_strap_addr: assert property (
        @(posedge clock) disable iff (!rst_n)
        capture |=> addr_r == $past(straps_s2_r.addr))
        else $error("address strap default wrong");
    a_soft_keeps: assert property (
        @(posedge clock) disable iff (!rst_n)
        soft_reset && !sticky_rst && !loader_write && !wr_spm
            |=> mode_r == $past(mode_r) && addr_r == $past(addr_r))
        else $error("soft reset changed special modes");
    a_loader: assert property (
        @(posedge clock) disable iff (!rst_n)
        loader_write && !sticky_rst |=> spm_val[7:0] ==
            $past(loader_data[7:0]))
        else $error("loader write lost");
    a_host_write: assert property (
        @(posedge clock) disable iff (!rst_n)
        s_host_spm_write |=> mode_r == $past(mgmt_req.wdata[7:5])
            && addr_r == $past(mgmt_req.wdata[4:0]))
        else $error("host write to special modes lost");
    a_addr_ack: assert property (
        @(posedge clock) disable iff (!rst_n)
        mgmt_ack |-> mgmt_req.phy_addr == addr_r)
        else $error("answered wrong address");
    a_no_foreign: assert property (
        @(posedge clock) disable iff (!rst_n)
        mgmt_req.valid && mgmt_req.phy_addr != addr_r |-> !mgmt_ack)
        else $error("answered foreign address");
    a_read_ctrl: assert property (
        @(posedge clock) disable iff (!rst_n)
        s_read_hit ##0 sel_mcs |=>
            mgmt_rdata[phy_mode_pkg::EDPD_EN_BIT] == $past(edpd_en_r)
            && mgmt_rdata[phy_mode_pkg::ENERGY_BIT] == $past(energy_r))
        else $error("control read data wrong");
    a_read_modes: assert property (
        @(posedge clock) disable iff (!rst_n)
        s_read_hit ##0 sel_spm |=> mgmt_rdata ==
            {8'h00, $past(mode_r), $past(addr_r)})
        else $error("special modes read data wrong");
    a_read_unmapped: assert property (
        @(posedge clock) disable iff (!rst_n)
        s_read_hit ##0 (!sel_mcs && !sel_spm)
            |=> mgmt_rdata == 16'h0000)
        else $error("unmapped register read nonzero");
    a_dec_ten: assert property (
        @(posedge clock) disable iff (!rst_n)
        mode_r[2:1] == 2'b00 |-> !mode_dec.speed_100
            && !mode_dec.autoneg_en && mode_dec.full_duplex == mode_r[0])
        else $error("10BASE-T mode decoded wrong");
    a_dec_hundred: assert property (
        @(posedge clock) disable iff (!rst_n)
        mode_r[2:1] == 2'b01 |-> mode_dec.speed_100
            && !mode_dec.autoneg_en && mode_dec.crs_on_tx == !mode_r[0])
        else $error("100BASE-TX mode decoded wrong");
    a_dec_special: assert property (
        @(posedge clock) disable iff (!rst_n)
        mode_r[2] |-> mode_dec.speed_100 == 1'b0
            && mode_dec.power_down == (mode_r == phy_mode_pkg::MODE_PWR_DOWN)
            && mode_dec.autoneg_en == (mode_r == phy_mode_pkg::MODE_ALL_CAP))
        else $error("special mode decoded wrong");

endmodule // phy_mode_config_regs

// File: test/mgmt_host.sv
`timescale 1ns/1ns

module mgmt_host (
    input wire logic clock,
    input wire logic mgmt_ack,
    input wire logic [15:0] mgmt_rdata,
    output phy_mode_pkg::mgmt_req_s mgmt_req
);
    initial mgmt_req = '0;

    // Callers keep every PHY on its own address
    task automatic access(input logic wr, input logic [4:0] pa,
                          input logic [4:0] ra, input logic [15:0] wd,
                          output logic ack, output logic [15:0] rd);
        @(posedge clock);
        #1 mgmt_req = {1'b1, wr, pa, ra, wd};
        #20 ack = mgmt_ack;
        @(posedge clock);
        #1 rd = mgmt_rdata;
        // Released fields flip so stale values cannot pass
        mgmt_req = {1'b0, ~mgmt_req[26:0]};
    endtask
endmodule // mgmt_host

// File: test/testbench.sv
`timescale 1ns/1ns

module testbench;
    logic clock, rst_n, soft_reset, port_phy_reset, ext_mode_port1;
    logic energy_raw, loader_write, mgmt_ack, low_power, ack;
    logic [15:0] loader_data, mgmt_rdata, rd;
    logic [4:0] scrambler_key;
    phy_mode_pkg::straps_s straps_raw;
    phy_mode_pkg::mode_dec_s mode_dec;
    phy_mode_pkg::mgmt_req_s mgmt_req;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;

    // Short timeout so the energy flag expires quickly
    phy_mode_config_regs #(.TIMEOUT_CYC(16), .IS_PORT1(1'b1)) DUT (
        .clock(clock), .rst_n(rst_n), .soft_reset(soft_reset),
        .port_phy_reset(port_phy_reset), .ext_mode_port1(ext_mode_port1),
        .straps_raw(straps_raw), .energy_raw(energy_raw),
        .mgmt_req(mgmt_req), .loader_write(loader_write),
        .loader_data(loader_data), .mgmt_ack(mgmt_ack),
        .mgmt_rdata(mgmt_rdata), .low_power(low_power),
        .scrambler_key(scrambler_key), .mode_dec(mode_dec)
    );

    mgmt_host host (
        .clock(clock), .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata),
        .mgmt_req(mgmt_req)
    );

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            $display("CHECK FAILED %0t timeout", $time);
            error_cnt++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
        n_compared++;
        if (seen !== exp) begin
            $display("CHECK FAILED %0t %s: %h vs %h", $time, what, seen, exp);
            error_cnt++;
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        wait_cyc(1);
        sig = 1'b0;
    endtask

    task automatic wr(input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd);
        host.access(1'b1, pa, ra, wd, ack, rd);
    endtask

    task automatic rd_chk(input logic [4:0] pa, input logic [4:0] ra,
                          input logic [15:0] exp, input string what);
        host.access(1'b0, pa, ra, 16'h0000, ack, rd);
        chk({15'h0000, ack}, 16'h0001, what);
        chk(rd, exp, what);
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        wait_cyc(5);
        rst_n = 1'b1;
        wait_cyc(3);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_energy();
        rd_chk(5'h03, 5'h11, 16'h0002, "ctrl reset");
        rd_chk(5'h03, 5'h12, 16'h00e3, "modes reset");
        chk({11'h000, scrambler_key}, 16'h0003, "key");
        wr(5'h03, 5'h11, 16'h2000);
        energy_raw = 1'b0;
        wait_cyc(6);
        rd_chk(5'h03, 5'h11, 16'h2002, "energy held");
        wait_cyc(25);
        rd_chk(5'h03, 5'h11, 16'h2000, "energy gone");
        chk({15'h0000, low_power}, 16'h0001, "low power");
        energy_raw = 1'b1;
        wait_cyc(4);
        chk({15'h0000, low_power}, 16'h0000, "woken");
        energy_raw = 1'b0;
        wait_cyc(25);
        pulse(soft_reset);
        rd_chk(5'h03, 5'h11, 16'h0000, "soft reset");
        chk({15'h0000, low_power}, 16'h0000, "awake");
        energy_raw = 1'b1;
        wait_cyc(5);
        rd_chk(5'h03, 5'h11, 16'h0002, "energy back");
        $display("test energy done");
    endtask

    task automatic t_modes();
        logic [4:0] dec [7] = '{5'b00001, 5'b00010, 5'b00101, 5'b00110,
                                5'b00000, 5'b00000, 5'b10000};
        for (int c = 0; c < 8; c++) begin
            wr(5'h03, 5'h12, {8'h00, c[2:0], 5'h03});
            rd_chk(5'h03, 5'h12, {8'h00, c[2:0], 5'h03}, "mode");
            if (c < 7) begin
                chk({11'h000, mode_dec}, {11'h000, dec[c]}, "dec");
            end else begin
                chk({14'h0000, mode_dec[4:3]}, 16'h0001, "dec");
            end
        end
        $display("test modes done");
    endtask

    task automatic t_address();
        wr(5'h03, 5'h12, 16'h00e9);
        host.access(1'b0, 5'h03, 5'h11, 16'h0000, ack, rd);
        chk({15'h0000, ack}, 16'h0000, "old addr");
        rd_chk(5'h09, 5'h12, 16'h00e9, "new addr");
        chk({11'h000, scrambler_key}, 16'h0009, "key");
        rd_chk(5'h09, 5'h05, 16'h0000, "unmapped");
        pulse(port_phy_reset);
        rd_chk(5'h03, 5'h12, 16'h00e3, "port reset");
        $display("test address done");
    endtask

    task automatic t_straps();
        straps_raw = {1'b0, 1'b1, 1'b0, 5'h04};
        do_reset();
        rd_chk(5'h04, 5'h12, 16'h0044, "forced");
        ext_mode_port1 = 1'b1;
        do_reset();
        rd_chk(5'h04, 5'h12, 16'h00c4, "external");
        loader_data = 16'h0065;
        pulse(loader_write);
        rd_chk(5'h05, 5'h12, 16'h0065, "loader");
        $display("test straps done");
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        soft_reset = 1'b0;
        port_phy_reset = 1'b0;
        ext_mode_port1 = 1'b0;
        straps_raw = {1'b1, 1'b0, 1'b0, 5'h03};
        energy_raw = 1'b1;
        loader_write = 1'b0;
        loader_data = 16'h0000;
        do_reset();
        t_energy();
        t_modes();
        t_address();
        t_straps();
        end_of_test();
    end
endmodule // testbench
